// [hdl/aasr_pkg.sv]
// Shared constants and carrier types for the auto-negotiation register bank.
// Assumes a 16-bit management register port with a 5-bit register address.
package aasr_pkg;

    // Register addresses
    localparam logic [4:0] ADDR_ADVERT   = 5'h04;
    localparam logic [4:0] ADDR_PARTNER  = 5'h05;
    localparam logic [4:0] ADDR_EXPAND   = 5'h06;
    localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h11;

    localparam int DATA_W = 16;
    localparam int SEL_W  = 5;
    localparam int IRQ_W  = 3;

    // Advertisement and partner word layout
    localparam int BIT_NEXT_PAGE   = 15;
    localparam int BIT_ACK         = 14;
    localparam int BIT_RESERVED_12 = 12;
    localparam int BIT_TEN_HALF    = 5;
    localparam int SEL_MSB         = 4;
    localparam int SEL_LSB         = 0;

    localparam logic [SEL_W-1:0]  SELECTOR_RST = 5'h01;
    // Partner word bits kept in storage; ack comes live, bit 12 reads zero
    localparam logic [DATA_W-1:0] PARTNER_KEEP = 16'hAFFF;

    // Expansion register layout
    localparam int EXP_LOC_ABLE  = 6;
    localparam int EXP_STOR_LOC  = 5;
    localparam int EXP_PD_FAULT  = 4;
    localparam int EXP_LP_NP     = 3;
    localparam int EXP_LOCAL_NEXT_PAGE_CAPABLE   = 2;
    localparam int EXP_PAGE_RX   = 1;
    localparam int EXP_LP_AN     = 0;
    localparam logic EXP_LOC_ABLE_VAL = 1'b1;
    localparam logic EXP_STOR_LOC_VAL = 1'b1;
    localparam logic EXP_LOCAL_NEXT_PAGE_CAPABLE_VAL  = 1'b1;

    // Interrupt status bits
    localparam int IRQ_PAGE     = 0;
    localparam int IRQ_PD_FAULT = 1;
    localparam int IRQ_LP_AN    = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    // A link code word delivered by the negotiation engine
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] word;
    } aasr_page_t;

endpackage

// [hdl/aasr_sticky.sv]
// Sticky flag bank: hardware sets, a clear request drops, set wins over clear.
// Assumes set and clear are single-clock-domain pulses or levels.
`timescale 1ns/1ps
module aasr_sticky #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Control
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clr,
    // State
    output logic      [WIDTH-1:0] flag_q
);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= set | (flag_q & ~clr);
        end
    end

endmodule

// [hdl/aasr_rise.sv]
// Rising-edge detector bank with a registered copy of the input levels.
// Assumes inputs are already synchronous to clk.
`timescale 1ns/1ps
module aasr_rise #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels in
    input  wire logic [WIDTH-1:0] level,
    // Registered level and one-cycle rise pulse
    output logic      [WIDTH-1:0] level_q,
    output logic      [WIDTH-1:0] rise
);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_q <= '0;
        end else begin
            level_q <= level;
        end
    end

    assign rise = level & ~level_q;

endmodule

// [hdl/aasr_top.sv]
// Auto-negotiation advertisement, partner ability and expansion registers.
// Assumes a negotiation engine on the same clock delivering received pages
// and status levels, and a management master on the plain register port.
`timescale 1ns/1ps
module aasr_top (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Strap
    input  wire logic                         strap_ten_half,
    // Negotiation engine
    input  wire aasr_pkg::aasr_page_t         page_in,
    input  wire logic                         partner_ack,
    input  wire logic                         an_complete,
    input  wire logic                         pd_fault,
    input  wire logic                         partner_local_next_page_capable,
    input  wire logic                         partner_an_able,
    // Register port
    input  wire logic [4:0]                   reg_addr,
    input  wire logic [aasr_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                         reg_we,
    input  wire logic                         reg_re,
    output logic      [aasr_pkg::DATA_W-1:0]  reg_rdata,
    // Advertised abilities to the engine
    output logic                              adv_ten_half,
    output logic      [aasr_pkg::SEL_W-1:0]   adv_selector,
    // Interrupt
    output logic                              irq
);

    // Address decode
    logic hit_advert;
    logic hit_partner;
    logic hit_expand;
    logic hit_stat;
    logic hit_mask;

    assign hit_advert  = (reg_addr == aasr_pkg::ADDR_ADVERT);
    assign hit_partner = (reg_addr == aasr_pkg::ADDR_PARTNER);
    assign hit_expand  = (reg_addr == aasr_pkg::ADDR_EXPAND);
    assign hit_stat    = (reg_addr == aasr_pkg::ADDR_IRQ_STAT);
    assign hit_mask    = (reg_addr == aasr_pkg::ADDR_IRQ_MASK);

    // ------------------------------------------------------------------
    // Advertisement register, low bits
    // ------------------------------------------------------------------
    logic strap_done_q;
    logic ten_half_q;
    logic [aasr_pkg::SEL_W-1:0] selector_q;

    // Strap is caught in the first clocked cycle after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ten_half_q <= 1'b0;
        end else if (!strap_done_q) begin
            ten_half_q <= strap_ten_half;
        end else if (reg_we && hit_advert) begin
            ten_half_q <= reg_wdata[aasr_pkg::BIT_TEN_HALF];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selector_q <= aasr_pkg::SELECTOR_RST;
        end else if (reg_we && hit_advert) begin
            selector_q <= reg_wdata[aasr_pkg::SEL_MSB:aasr_pkg::SEL_LSB];
        end
    end

    // New abilities reach the wire straight from the register, without waiting for a renegotiation
    assign adv_ten_half = ten_half_q;
    assign adv_selector = selector_q;

    // ------------------------------------------------------------------
    // Engine status levels, registered, with rise detection
    // ------------------------------------------------------------------
    logic [3:0] lvl_in;
    logic [3:0] lvl_q;
    logic [3:0] lvl_rise;

    assign lvl_in = {partner_ack, pd_fault, partner_local_next_page_capable, partner_an_able};

    aasr_rise #(
        .WIDTH (4)
    ) u_levels (
        .clk     (clk),
        .rst     (rst),
        .level   (lvl_in),
        .level_q (lvl_q),
        .rise    (lvl_rise)
    );

    logic ack_q;
    logic pd_fault_q;
    logic lp_np_q;
    logic lp_an_q;

    assign ack_q      = lvl_q[3];
    assign pd_fault_q = lvl_q[2];
    assign lp_np_q    = lvl_q[1];
    assign lp_an_q    = lvl_q[0];

    // ------------------------------------------------------------------
    // Partner ability register
    // ------------------------------------------------------------------
    logic [aasr_pkg::DATA_W-1:0] partner_q;
    logic                        partner_load;

    // Base page is held once negotiation completes, unless next pages
    // are exchanged, in which case later pages may overwrite it
    assign partner_load = page_in.valid && (!an_complete || partner_local_next_page_capable);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partner_q <= aasr_pkg::ZERO_WORD;
        end else if (partner_load) begin
            partner_q <= page_in.word & aasr_pkg::PARTNER_KEEP;
        end
    end

    logic [aasr_pkg::DATA_W-1:0] partner_view;

    always_comb begin
        partner_view                         = partner_q;
        partner_view[aasr_pkg::BIT_ACK]      = ack_q;
        partner_view[aasr_pkg::BIT_RESERVED_12] = 1'b0;
    end

    // ------------------------------------------------------------------
    // Expansion register
    // ------------------------------------------------------------------
    logic page_rx_q;
    logic page_rx_clr;

    assign page_rx_clr = reg_re && hit_expand;

    aasr_sticky #(
        .WIDTH (1)
    ) u_page_flag (
        .clk    (clk),
        .rst    (rst),
        .set    (page_in.valid),
        .clr    (page_rx_clr),
        .flag_q (page_rx_q)
    );

    logic [aasr_pkg::DATA_W-1:0] expand_view;

    always_comb begin
        expand_view                         = aasr_pkg::ZERO_WORD;
        expand_view[aasr_pkg::EXP_LOC_ABLE] = aasr_pkg::EXP_LOC_ABLE_VAL;
        expand_view[aasr_pkg::EXP_STOR_LOC] = aasr_pkg::EXP_STOR_LOC_VAL;
        expand_view[aasr_pkg::EXP_PD_FAULT] = pd_fault_q;
        expand_view[aasr_pkg::EXP_LP_NP]    = lp_np_q;
        expand_view[aasr_pkg::EXP_LOCAL_NEXT_PAGE_CAPABLE]  = aasr_pkg::EXP_LOCAL_NEXT_PAGE_CAPABLE_VAL;
        expand_view[aasr_pkg::EXP_PAGE_RX]  = page_rx_q;
        expand_view[aasr_pkg::EXP_LP_AN]    = lp_an_q;
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    logic [aasr_pkg::IRQ_W-1:0] irq_set;
    logic [aasr_pkg::IRQ_W-1:0] irq_clr;
    logic [aasr_pkg::IRQ_W-1:0] irq_stat_q;
    logic [aasr_pkg::IRQ_W-1:0] irq_mask_q;

    always_comb begin
        irq_set                         = '0;
        irq_set[aasr_pkg::IRQ_PAGE]     = page_in.valid;
        irq_set[aasr_pkg::IRQ_PD_FAULT] = lvl_rise[2];
        irq_set[aasr_pkg::IRQ_LP_AN]    = lvl_rise[0];
    end

    // Write one to clear; a same-cycle event keeps the bit set
    assign irq_clr = (reg_we && hit_stat) ? reg_wdata[aasr_pkg::IRQ_W-1:0] : '0;

    aasr_sticky #(
        .WIDTH (aasr_pkg::IRQ_W)
    ) u_irq_stat (
        .clk    (clk),
        .rst    (rst),
        .set    (irq_set),
        .clr    (irq_clr),
        .flag_q (irq_stat_q)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask_q <= aasr_pkg::IRQ_MASK_RST;
        end else if (reg_we && hit_mask) begin
            irq_mask_q <= reg_wdata[aasr_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Read path: data stands in the cycle after the read strobe
    // ------------------------------------------------------------------
    logic [aasr_pkg::DATA_W-1:0] read_mux;

    always_comb begin
        read_mux = aasr_pkg::ZERO_WORD;
        case (1'b1)
            hit_advert: begin
                read_mux[aasr_pkg::BIT_TEN_HALF]                  = ten_half_q;
                read_mux[aasr_pkg::SEL_MSB:aasr_pkg::SEL_LSB]     = selector_q;
            end
            hit_partner: begin
                read_mux = partner_view;
            end
            hit_expand: begin
                read_mux = expand_view;
            end
            hit_stat: begin
                read_mux[aasr_pkg::IRQ_W-1:0] = irq_stat_q;
            end
            hit_mask: begin
                read_mux[aasr_pkg::IRQ_W-1:0] = irq_mask_q;
            end
            default: begin
                read_mux = aasr_pkg::ZERO_WORD;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= aasr_pkg::ZERO_WORD;
        end else if (reg_re) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= aasr_pkg::ZERO_WORD;
        end
    end

endmodule

// [verif/aasr_checker.sv]
// Port-level checks of the negotiation register bank.
// Assumes one clock domain and the bank's own port names.
`timescale 1ns/1ps
module aasr_checker (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Engine side
    input wire aasr_pkg::aasr_page_t page_in,
    input wire logic                 partner_ack,
    input wire logic                 an_complete,
    input wire logic                 pd_fault,
    input wire logic                 partner_local_next_page_capable,
    input wire logic                 partner_an_able,
    // Register port
    input wire logic [4:0]           reg_addr,
    input wire logic [15:0]          reg_wdata,
    input wire logic                 reg_we,
    input wire logic                 reg_re,
    input wire logic [15:0]          reg_rdata,
    // Outputs
    input wire logic                 adv_ten_half,
    input wire logic [4:0]           adv_selector,
    input wire logic                 irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic rd_exp = reg_re && reg_addr == aasr_pkg::ADDR_EXPAND;
    wire logic rd_lp  = reg_re && reg_addr == aasr_pkg::ADDR_PARTNER;
    wire logic wr_adv = reg_we && reg_addr == aasr_pkg::ADDR_ADVERT;

    exp_fixed_a: assert property (rd_exp |=> reg_rdata[15:5] == 11'h003 && reg_rdata[2])
        else $error("expansion fixed bits wrong");
    exp_status_a: assert property (rd_exp && $stable({pd_fault, partner_local_next_page_capable, partner_an_able})
        |=> {reg_rdata[4:3], reg_rdata[0]} == $past({pd_fault, partner_local_next_page_capable, partner_an_able}))
        else $error("expansion status bits wrong");
    ack_live_a: assert property (rd_lp && $stable(partner_ack)
        |=> reg_rdata[14] == $past(partner_ack) && !reg_rdata[12]) else $error("partner ack or bit 12 wrong");
    partner_load_a: assert property (page_in.valid && (!an_complete || partner_local_next_page_capable) ##1 rd_lp
        |=> (reg_rdata & aasr_pkg::PARTNER_KEEP) == ($past(page_in.word, 2) & aasr_pkg::PARTNER_KEEP))
        else $error("partner word not loaded");
    page_keep_a: assert property (page_in.valid && rd_exp ##1 rd_exp |=> reg_rdata[1])
        else $error("page flag lost on read clear");
    read_clear_a: assert property (rd_exp && !page_in.valid ##1 rd_exp |=> !reg_rdata[1])
        else $error("page flag not cleared by read");
    adv_write_a: assert property (wr_adv |=> {adv_ten_half, adv_selector} == $past(reg_wdata[5:0]))
        else $error("advert write not taken");
    adv_hold_a: assert property (!wr_adv |=> $stable(adv_selector))
        else $error("selector changed without write");

    cover property (page_in.valid && an_complete && partner_local_next_page_capable);
    cover property (rd_exp ##1 rd_exp);
    cover property ($rose(irq));
endmodule

bind aasr_top aasr_checker i_aasr_checker (.clk, .rst, .page_in, .partner_ack, .an_complete, .pd_fault,
    .partner_local_next_page_capable, .partner_an_able, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .adv_ten_half, .adv_selector, .irq);

// [verif/aasr_engine_model.sv]
// Negotiation engine stand-in: received pages and partner status levels.
// Assumes the bench calls its tasks and shares the bank's clock.
`timescale 1ns/1ps
module aasr_engine_model (
    // Clock
    input wire logic             clk,
    // Engine outputs
    output aasr_pkg::aasr_page_t page_in,
    output logic                 partner_ack,
    output logic                 an_complete,
    output logic                 pd_fault,
    output logic                 partner_local_next_page_capable,
    output logic                 partner_an_able
);
    initial begin
        page_in = '0;
        {partner_ack, an_complete, pd_fault, partner_local_next_page_capable, partner_an_able} = 5'h00;
    end

    // One-cycle page pulse; the word is scrambled outside the pulse
    task automatic send(input logic [15:0] w);
        @(posedge clk);
        page_in <= {1'b1, w};
        @(posedge clk);
        page_in <= {1'b0, ~w};
    endtask

    // Negotiation restart after software changes the advertisement
    task automatic restart();
        @(posedge clk);
        an_complete <= 1'b0;
    endtask

    // Order: ack, complete, fault, next-page able, negotiation able
    task automatic levels(input logic [4:0] v);
        @(posedge clk);
        {partner_ack, an_complete, pd_fault, partner_local_next_page_capable, partner_an_able} <= v;
    endtask
endmodule

// [verif/tb_autoneg_ability_status_regs.sv]
// Self-checking bench for the negotiation register bank.
// Assumes the engine model drives all engine inputs on the one 40 MHz clock.
`timescale 1ns/1ps
module tb_autoneg_ability_status_regs;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 strap_ten_half;
    aasr_pkg::aasr_page_t page_in;
    logic                 partner_ack, an_complete, pd_fault, partner_local_next_page_capable, partner_an_able;
    logic [4:0]           reg_addr;
    logic [15:0]          reg_wdata;
    logic                 reg_we;
    logic                 reg_re;
    logic [15:0]          reg_rdata;
    logic                 adv_ten_half, irq;
    logic [4:0]           adv_selector;
    logic [15:0]          d0, d1;
    int                   n_mismatch = 0;
    int                   tests_run = 0;

    always #12.5 clk = ~clk;

    aasr_top i_aasr_top (.clk, .rst, .strap_ten_half, .page_in, .partner_ack, .an_complete, .pd_fault,
        .partner_local_next_page_capable, .partner_an_able, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .adv_ten_half, .adv_selector, .irq);
    aasr_engine_model i_aasr_engine_model (.clk, .page_in, .partner_ack, .an_complete, .pd_fault,
        .partner_local_next_page_capable, .partner_an_able);

    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask

    // Two back-to-back reads of one address
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        #1 d0 = reg_rdata;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 d1 = reg_rdata;
    endtask

    task automatic t_reset();
        rd(5'h04);
        chk("advert", d0, 16'h0021);
        rd(5'h05);
        chk("partner", d0, 16'h0000);
        rd(5'h06);
        chk("expansion", d0, 16'h0064);
    endtask

    task automatic t_advert();
        wr(5'h04, 16'hFFFF);
        i_aasr_engine_model.restart();
        rd(5'h04);
        chk("advert", d0, 16'h003F);
        chk("advert pins", {10'h000, adv_ten_half, adv_selector}, 16'h003F);
        wr(5'h04, 16'h0000);
        i_aasr_engine_model.restart();
        rd(5'h04);
        chk("advert", d1, 16'h0000);
        wr(5'h05, 16'hEFFF);
        wr(5'h06, 16'hFFFF);
        rd(5'h05);
        chk("partner", d0, 16'h0000);
        rd(5'h06);
        chk("expansion", d0, 16'h0064);
        rd(5'h1F);
        chk("unmapped", d0, 16'h0000);
    endtask

    task automatic t_page();
        wr(5'h11, 16'h0001);
        i_aasr_engine_model.levels(5'b10000);
        i_aasr_engine_model.send(16'hFFFF);
        rd(5'h05);
        chk("partner", d0, 16'hEFFF);
        chk("irq", {15'h0000, irq}, 16'h0001);
        rd(5'h06);
        chk("expansion", d0, 16'h0066);
        chk("expansion", d1, 16'h0064);
        wr(5'h10, 16'h0001);
        repeat (2) @(posedge clk);
        #1 chk("irq", {15'h0000, irq}, 16'h0000);
    endtask

    task automatic t_next();
        i_aasr_engine_model.levels(5'b01000);
        i_aasr_engine_model.send(16'h1234);
        rd(5'h05);
        chk("partner", d0, 16'hAFFF);
        i_aasr_engine_model.levels(5'b01111);
        i_aasr_engine_model.send(16'h0421);
        rd(5'h05);
        chk("partner", d0, 16'h0421);
        // Read the partner word in the cycle right after the page lands
        fork
            i_aasr_engine_model.send(16'hA5A5);
            begin
                @(posedge clk);
                rd(5'h05);
            end
        join
        chk("partner", d0, 16'hA5A5);
        rd(5'h06);
        chk("expansion", d0, 16'h007F);
        chk("expansion", d1, 16'h007D);
        rd(5'h10);
        chk("irq status", d0, 16'h0007);
        wr(5'h10, 16'h0006);
        rd(5'h10);
        chk("irq status", d0, 16'h0001);
        rd(5'h11);
        chk("irq mask", d0, 16'h0001);
    endtask

    task automatic t_race();
        fork
            i_aasr_engine_model.send(16'h0000);
            rd(5'h06);
        join
        chk("expansion", d0, 16'h007D);
        chk("expansion", d1, 16'h007F);
        rd(5'h06);
        chk("expansion", d1, 16'h007D);
    endtask

    // Mid-run reset with the strap held low
    task automatic t_strap();
        @(posedge clk);
        rst            <= 1'b1;
        strap_ten_half <= 1'b0;
        @(posedge clk);
        #1 chk("irq", {15'h0000, irq}, 16'h0000);
        chk("advert pins", {10'h000, adv_ten_half, adv_selector}, 16'h0001);
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(5'h04);
        chk("advert", d0, 16'h0001);
        chk("advert pins", {10'h000, adv_ten_half, adv_selector}, 16'h0001);
        rd(5'h05);
        chk("partner", d0, 16'h0000);
        rd(5'h06);
        chk("expansion", d0, 16'h007D);
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        strap_ten_half <= 1'b1;
        reg_addr       <= 5'h00;
        reg_wdata      <= 16'h0000;
        reg_we         <= 1'b0;
        reg_re         <= 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_advert();
        t_page();
        t_next();
        t_race();
        t_strap();
        final_report();
    end
endmodule
